// ---- logic/vrp_pkg.sv ----
// Constants, register indices and carrier types for the per-phase
// voltage rms and total active power block.
// Assumes one 25 MHz clock and an 8 kHz sample strobe from the ADC path.
`default_nettype none
package vrp_pkg;

    // ------------------------------------------------------------
    // Widths and rates
    // ------------------------------------------------------------
    localparam int DW = 24;
    localparam int NPH = 3;
    localparam int MW = 2 * DW + 2;
    localparam int RB = DW + 1;
    localparam int CLK_HZ = 25_000_000;
    localparam int SAMPLE_HZ = 8000;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

    // ------------------------------------------------------------
    // Filter and scaling constants
    // ------------------------------------------------------------
    // Pole 2^-9 at 8 kHz: tau 64 ms, about 7 tau inside 440 ms
    localparam int RMS_SETTLE_MS = 440;
    localparam int RMS_LPF_SHIFT = 9;
    localparam int PWR_SETTLE_FAST_MS = 650;
    localparam int PWR_SETTLE_SLOW_MS = 1300;
    localparam int PWR_LPF_SHIFT_FAST = 9;
    localparam int PWR_LPF_SHIFT_SLOW = 10;
    // Product dc at full scale over 2^23 lands on 33,516,139 / 16
    localparam int PWR_SCALE_SHIFT = 23;
    localparam int OS_SCALE_SHIFT = 7;
    localparam int LRIP_LOG2 = 13;
    localparam logic [DW-1:0] RMS_FULL_SCALE = 24'h3FF6A6;
    localparam logic [1:0] WIRING_DELTA = 2'b01;
    localparam int PHASE_B = 1;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [3:0] REG_VRMS = 4'h0;
    localparam logic [3:0] REG_VAVG = 4'h4;
    localparam logic [3:0] REG_VOS = 4'h8;
    localparam logic [3:0] REG_WATT = 4'hC;

    // ------------------------------------------------------------
    // Carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NPH-1:0][DW-1:0] volt;
        logic [NPH-1:0][DW-1:0] curr;
    } vrp_samples_t;

endpackage : vrp_pkg
`default_nettype wire

// ---- logic/vrp_top.sv ----
// Voltage rms, low-ripple rms averages and total active power per phase.
// Assumes sample words and strobe come from logic on the same clock.
// Summary of operation
// RULE1: Signed 24-bit rms per phase, three registers
// RULE2: Refresh rms registers every 8 kHz sample
// RULE3: Full-scale sine reads 4,191,910, any frequency
// RULE4: Rms settles within 440 ms from zero
// RULE5: Rms read as 32 bits, top byte zero
// RULE6: Average of last 8192 rms, every 1.024 s
// RULE7: Averages signed 24-bit, settle by 2.048 s
// RULE8: Add 128 times offset before square root
// RULE9: Offset sign-extended to 28, top nibble zero
// RULE10: Delta wiring zeroes all phase B power
// RULE11: Delta phase B rms is A-to-C line voltage
// RULE12: Multiply v and i, low-pass for power
// RULE13: Filter strength bit picks settling and attenuation
// RULE14: Power register scaled to full-scale constant over 16
// RULE15: Power registers readable over the serial port
// RULE16: Host corrects mean-absolute current readings itself
// RULE17: Host reads rms near voltage zero crossings
// RULE18: Results hold between updates for coherent reads
`timescale 1ns/1ps
`default_nettype none
module vrp_top (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Sample stream
    input wire vrp_pkg::vrp_samples_t smp,
    input wire logic smp_valid,
    // Configuration
    input wire logic [1:0] wiring_configuration_select,
    input wire logic power_filter_strength_select,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Status
    output logic rms_update
);
    import vrp_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clamp a wide signed value into the 24-bit result range
    function automatic logic [DW-1:0] f_sat(input logic signed [2*DW:0] x);
        // Bounds made signed, else negatives compare as huge positives
        if (x > $signed((2*DW+1)'({1'b0, {(DW-1){1'b1}}})))
            return {1'b0, {(DW-1){1'b1}}};
        else if (x < -$signed((2*DW+1)'({1'b1, {(DW-1){1'b0}}})))
            return {1'b1, {(DW-1){1'b0}}};
        else
            return x[DW-1:0];
    endfunction : f_sat

    // Results go out with the upper byte cleared
    function automatic logic [31:0] f_pad(input logic [DW-1:0] x);
        return {8'h00, x};
    endfunction : f_pad

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_ROOT = 4'b0100,
        ST_STORE = 4'b1000
    } vrp_state_t;

    vrp_state_t state;
    logic [1:0] ph;
    logic [4:0] bi;
    logic [RB-1:0] rt;
    logic [MW:0] sarg;
    logic [LRIP_LOG2-1:0] lcnt;
    logic delta;
    logic signed [DW-1:0] vos [NPH];
    logic [DW-1:0] vrms [NPH];
    logic [DW-1:0] vavg [NPH];
    logic [DW-1:0] watt [NPH];
    logic [MW-1:0] msq [NPH];
    logic signed [2*DW-1:0] pflt [NPH];
    logic [DW+LRIP_LOG2-1:0] lacc [NPH];
    logic signed [DW:0] vin [NPH];
    logic [MW-1:0] next_msq [NPH];
    logic signed [2*DW-1:0] next_pflt [NPH];
    logic signed [MW+1:0] arg;
    logic [RB-1:0] trial;
    logic [DW-1:0] rms_new;
    logic [DW+LRIP_LOG2-1:0] lsum;

    assign delta = (wiring_configuration_select == WIRING_DELTA);

    // ------------------------------------------------------------
    // Per-sample datapath
    // ------------------------------------------------------------
    // Squares, power products and their one-pole low-pass updates
    always_comb begin
        for (int p = 0; p < NPH; p++) begin
            logic signed [MW:0] mdiff;
            logic signed [2*DW:0] pdiff;
            logic signed [MW-1:0] sq;
            int psh;
            mdiff = '0;
            pdiff = '0;
            sq = '0;
            psh = power_filter_strength_select ? PWR_LPF_SHIFT_SLOW
                                               : PWR_LPF_SHIFT_FAST; // RULE13
            vin[p] = $signed({smp.volt[p][DW-1], smp.volt[p]});
            if (delta && p == PHASE_B) begin
                vin[p] = $signed({smp.volt[0][DW-1], smp.volt[0]})
                       - $signed({smp.volt[2][DW-1], smp.volt[2]}); // RULE11
            end
            // Square at full width; inside a cast it would shrink to vin's size
            sq = vin[p] * vin[p];
            mdiff = $signed({1'b0, sq}) - $signed({1'b0, msq[p]});
            next_msq[p] = msq[p] + MW'($unsigned(mdiff >>> RMS_LPF_SHIFT)); // RULE4
            pdiff = $signed(smp.volt[p]) * $signed(smp.curr[p]) - pflt[p]; // RULE12
            next_pflt[p] = pflt[p] + (2*DW)'(pdiff >>> psh);
        end
    end

    // Mean squares and filtered power advance once per sample
    always_ff @(posedge clk) begin
        for (int p = 0; p < NPH; p++) begin
            if (srst) begin
                msq[p] <= '0;
                pflt[p] <= '0;
                watt[p] <= '0;
            end else if (smp_valid && state == ST_IDLE) begin
                msq[p] <= next_msq[p];
                if (delta && p == PHASE_B) begin
                    pflt[p] <= '0; // RULE10
                    watt[p] <= '0; // RULE10
                end else begin
                    pflt[p] <= next_pflt[p];
                    watt[p] <= f_sat((2*DW+1)'(next_pflt[p] >>> PWR_SCALE_SHIFT)); // RULE14
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Square root sequencer
    // ------------------------------------------------------------
    // Offset is sign-extended then scaled by 128 ahead of the root
    always_comb begin
        arg = $signed({2'b00, msq[ph]})
            + ((MW+2)'(vos[ph]) <<< OS_SCALE_SHIFT); // RULE8
        trial = rt | (RB'(1) << bi);
        rms_new = f_sat((2*DW+1)'(rt)); // RULE1
        lsum = lacc[ph] + (DW+LRIP_LOG2)'(rms_new);
    end

    // One bit of the root per cycle; phases run in turn.
    // Serial root keeps one multiplier; 81 cycles fits in 3125.
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            ph <= '0;
            bi <= '0;
            rt <= '0;
            sarg <= '0;
            rms_update <= 1'b0;
        end else begin
            rms_update <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (smp_valid) begin
                        ph <= '0;
                        state <= ST_LOAD; // RULE2
                    end
                end
                ST_LOAD: begin
                    sarg <= arg[MW+1] ? '0 : arg[MW:0];
                    rt <= '0;
                    bi <= 5'(RB - 1);
                    state <= ST_ROOT;
                end
                ST_ROOT: begin
                    if ((2*RB+1)'(trial * trial) <= (2*RB+1)'(sarg)) begin
                        rt <= trial; // RULE3
                    end
                    if (bi == '0) begin
                        state <= ST_STORE;
                    end else begin
                        bi <= bi - 5'd1;
                    end
                end
                ST_STORE: begin
                    if (ph == 2'(NPH - 1)) begin
                        rms_update <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        ph <= ph + 2'd1;
                        state <= ST_LOAD;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    // Written only in the store cycle so reads never see a partial root
    always_ff @(posedge clk) begin
        if (srst) begin
            lcnt <= '0;
            for (int p = 0; p < NPH; p++) begin
                vrms[p] <= '0;
                vavg[p] <= '0;
                lacc[p] <= '0;
            end
        end else if (state == ST_STORE) begin
            vrms[ph] <= rms_new; // RULE18
            if (lcnt == '1) begin
                vavg[ph] <= lsum[DW+LRIP_LOG2-1:LRIP_LOG2]; // RULE6
                lacc[ph] <= '0;
            end else begin
                lacc[ph] <= lsum; // RULE7
            end
            if (ph == 2'(NPH - 1)) begin
                lcnt <= lcnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Offset registers are the only writable words
    always_ff @(posedge clk) begin
        for (int p = 0; p < NPH; p++) begin
            if (srst) begin
                vos[p] <= '0;
            end else if (reg_wr && reg_addr == REG_VOS + 4'(p)) begin
                vos[p] <= reg_wdata[DW-1:0];
            end
        end
    end

    // Reads answer one cycle later; unmapped indices read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_rdata <= '0;
            for (int p = 0; p < NPH; p++) begin
                if (reg_addr == REG_VRMS + 4'(p))
                    reg_rdata <= f_pad(vrms[p]); // RULE5
                if (reg_addr == REG_VAVG + 4'(p))
                    reg_rdata <= f_pad(vavg[p]);
                if (reg_addr == REG_VOS + 4'(p))
                    reg_rdata <= {4'h0, {4{vos[p][DW-1]}}, vos[p]}; // RULE9
                if (reg_addr == REG_WATT + 4'(p))
                    reg_rdata <= f_pad(watt[p]); // RULE15
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_rms_refresh;
        smp_valid && state == ST_IDLE |-> ##[2:90] rms_update;
    endproperty
    a_rms_refresh: assert property (p_rms_refresh) else $error("rms late"); // RULE2

    property p_rms_hold;
        state != ST_STORE |=> $stable(vrms[0]) && $stable(vrms[2]);
    endproperty
    a_rms_hold: assert property (p_rms_hold) else $error("rms moved"); // RULE18

    property p_rms_pad;
        reg_rd && reg_addr == REG_VRMS |=> reg_rvalid && reg_rdata[31:24] == 8'h00;
    endproperty
    a_rms_pad: assert property (p_rms_pad) else $error("rms pad"); // RULE5

    property p_os_pad;
        reg_rd && reg_addr == REG_VOS + 4'd1
        |=> reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}};
    endproperty
    a_os_pad: assert property (p_os_pad) else $error("offset pad"); // RULE9

    property p_os_write;
        reg_wr && reg_addr == REG_VOS
        |=> vos[0] == $past(reg_wdata[DW-1:0]) ##1 reg_wr || $stable(vos[0]);
    endproperty
    a_os_write: assert property (p_os_write) else $error("offset write"); // RULE8

    property p_delta_zero;
        delta && smp_valid && state == ST_IDLE |=> watt[PHASE_B] == '0;
    endproperty
    a_delta_zero: assert property (p_delta_zero) else $error("B power"); // RULE10

    property p_root_exact;
        state == ST_STORE |-> (2*RB+1)'(rt * rt) <= (2*RB+1)'(sarg)
            && (2*RB+3)'((rt + 1'b1) * (rt + 1'b1)) > (2*RB+3)'(sarg);
    endproperty
    a_root_exact: assert property (p_root_exact) else $error("bad root"); // RULE3

    property p_avg_hold;
        !(state == ST_STORE && lcnt == '1) |=> $stable(vavg[0]);
    endproperty
    a_avg_hold: assert property (p_avg_hold) else $error("avg moved"); // RULE6

    property p_phase_walk;
        state == ST_STORE && ph != 2'(NPH - 1) |=> state == ST_LOAD ##1 ph == $past(ph, 2) + 2'd1;
    endproperty
    a_phase_walk: assert property (p_phase_walk) else $error("phase"); // RULE1

    c_update: cover property (rms_update);
    c_delta: cover property (delta && rms_update);
    c_avg: cover property (state == ST_STORE && lcnt == '1);
    c_rd_os: cover property (reg_wr && reg_addr == REG_VOS ##1 reg_rd && reg_addr == REG_VOS);

endmodule : vrp_top
`default_nettype wire

// ---- test/vrp_host.sv ----
// Host register master model for the rms and power block.
// Assumes one clock; strobes change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module vrp_host (
    // Clock
    input wire logic clk,
    // Register port
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic [31:0] reg_wdata,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = 32'h0;
        reg_rd = 1'b0;
    end
    // One-cycle write strobe; data inverted after so nothing stale lingers
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    // Read strobe; answer taken in the cycle after the taking edge
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic ok);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask : rd
    // Mean-absolute current words are corrected here; the block keeps no coefficients
    function automatic logic [31:0] mav_fix(input logic [31:0] raw, gain, ofs);
        return 32'(raw * gain) + ofs;
    endfunction : mav_fix
endmodule : vrp_host
`default_nettype wire

// ---- test/voltage_rms_and_active_power_tb.sv ----
// Self-checking bench: offsets, rms readback, delta wiring, power filter.
// Assumes vrp_top with a strobe register port and the host model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module voltage_rms_and_active_power_tb;
    import vrp_pkg::*;
    logic clk, srst, smp_valid, fsel, reg_wr, reg_rd, reg_rvalid, rms_update;
    logic [1:0] wsel;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    vrp_samples_t smp;
    int checked = 0;
    int failures = 0;
    int cycles = 0;
    // ----------------------------------------
    // Design, host and clock
    // ----------------------------------------
    vrp_top vrp_top_i (.clk(clk), .srst(srst), .smp(smp), .smp_valid(smp_valid),
        .wiring_configuration_select(wsel), .power_filter_strength_select(fsel),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rms_update(rms_update));
    vrp_host vrp_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard, well above the five hundred or so cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            $display("timeout after %0d cycles", cycles);
            summarize();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    task automatic reset();
        @(posedge clk);
        #1;
        srst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
    endtask : reset
    task automatic chk_rd(input string n, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic ok;
        vrp_host_i.rd(a, d, ok);
        `CHK(n, 1'b1, ok)
        `CHK(n, e, d)
    endtask : chk_rd
    // One sample; waits for the rms refresh, then leaves a gap of 20 cycles
    task automatic sample(input logic [23:0] va, vb, vc, ia, ib, ic);
        int n;
        @(posedge clk);
        #1;
        smp.volt = {vc, vb, va};
        smp.curr = {ic, ib, ia};
        smp_valid = 1'b1;
        @(posedge clk);
        #1;
        smp_valid = 1'b0;
        n = 1;
        while (rms_update !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("refresh latency", 82, n)
        repeat (20) @(posedge clk);
    endtask : sample
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        chk_rd("unmapped", 4'h3, 32'h0);
        vrp_host_i.wr(REG_VRMS, 32'h00123456);
        chk_rd("ro write", REG_VRMS, 32'h0);
        chk_rd("avg before period", REG_VAVG, 32'h0);
        vrp_host_i.wr(REG_VOS, 32'hFF800001);
        chk_rd("os negative", REG_VOS, 32'h0F800001);
        vrp_host_i.wr(REG_VOS, 32'hF0000008);
        chk_rd("os positive", REG_VOS, 32'h00000008);
        $display("test regs done");
    endtask : t_regs
    // Zero input: rms is the root of 128 times the offset alone
    task automatic t_offset();
        vrp_host_i.wr(REG_VOS, 32'h00000002);
        vrp_host_i.wr(REG_VOS + 4'h1, 32'h00000008);
        vrp_host_i.wr(REG_VOS + 4'h2, 32'h00FFFFFF);
        sample(0, 0, 0, 0, 0, 0);
        chk_rd("rms a", REG_VRMS, 32'h00000010);
        chk_rd("rms b", REG_VRMS + 4'h1, 32'h00000020);
        chk_rd("rms c", REG_VRMS + 4'h2, 32'h0);
        chk_rd("os b", REG_VOS + 4'h1, 32'h00000008);
        repeat (30) @(posedge clk);
        chk_rd("rms a held", REG_VRMS, 32'h00000010);
        $display("test offset done");
    endtask : t_offset
    // Delta: B rms from A minus C, B power forced to zero
    task automatic t_delta();
        reset();
        wsel = WIRING_DELTA;
        sample(24'h400000, 24'h400000, 24'h400000, 24'h400000, 24'h400000, 24'h400000);
        chk_rd("delta rms b", REG_VRMS + 4'h1, 32'h0);
        chk_rd("delta rms a", REG_VRMS, 32'h0002D413);
        chk_rd("delta watt b", REG_WATT + 4'h1, 32'h0);
        chk_rd("delta watt a", REG_WATT, 32'h00001000);
        $display("test delta done");
    endtask : t_delta
    // First-sample power: product 2^44, pole 2^-9 or 2^-10, scaled by 2^-23
    task automatic t_power();
        reset();
        wsel = 2'b00;
        fsel = 1'b0;
        sample(24'h400000, 24'h400000, 24'h400000, 24'h400000, 24'h400000, 24'hC00000);
        chk_rd("watt a fast", REG_WATT, 32'h00001000);
        chk_rd("watt b wye", REG_WATT + 4'h1, 32'h00001000);
        chk_rd("watt c neg", REG_WATT + 4'h2, 32'h00FFF000);
        reset();
        fsel = 1'b1;
        sample(24'h400000, 0, 0, 24'h400000, 0, 0);
        chk_rd("watt a slow", REG_WATT, 32'h00000800);
        $display("test power done");
    endtask : t_power
    // ----------------------------------------
    // Main sequence; reads follow each refresh
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        smp_valid = 1'b0;
        smp = '0;
        wsel = 2'b00;
        fsel = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        t_regs();
        t_offset();
        t_delta();
        t_power();
        summarize();
    end
endmodule : voltage_rms_and_active_power_tb
`default_nettype wire
